/* rtl/fault_led_aggregator.sv */
// Fault, status and locator LED controller with an AXI4-Lite register port
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "fault_led_cfg.svh"
// ==========================================================
module fault_led_aggregator import fault_led_pkg::*; #(
  parameter int NUM_SRC = 4, // Tracked command sources
  parameter int BLINK_HALF_CYC = `BLINK_HALF_NS / `CLK_PERIOD_NS // Half blink period
) (
  input wire logic aclk, // 100 MHz clock
  input wire logic aresetn, // Synchronous reset, low active
  input wire logic ce, // Clock enable, freezes all state when low
  input wire pin_t pins, // Board level inputs
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [`AXI_AW-1:0] awaddr, // Write address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response code
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [`AXI_AW-1:0] araddr, // Read address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response code
  output led_t leds // All lamps
);
  localparam int SW = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  // ==========================================================
  // Parameter checks
  if (NUM_SRC < 4 || NUM_SRC > 16) begin : g_chk_src
    $error("NUM_SRC must lie between 4 and 16");
  end
  if (BLINK_HALF_CYC < 1 || BLINK_HALF_CYC >= (1 << `BLINK_W)) begin : g_chk_blink
    $error("BLINK_HALF_CYC does not fit the blink counter");
  end

  // ==========================================================
  // State
  typedef struct packed {
    pin_t sync1, sync2, prev;
    slot_t [NUM_SRC-1:0] tab;
    logic [2:0] psu_keep;
    logic [`BLINK_W-1:0] blink_cnt;
    logic blink, redun, cmd_ok, cmd_rej;
    sev_t sev;
    logic awready;
    logic [`AXI_AW-1:0] aw_addr;
    logic wready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    led_t leds;
  } state_t;
  state_t q, d;
  // Severity order used for the worst-wins pick
  function automatic logic [2:0] rank(input logic [2:0] l);
    case (l)
      LVL_DEGR: rank = 3'h1;
      LVL_NC: rank = 3'h2;
      LVL_CRIT: rank = 3'h3;
      LVL_NR: rank = 3'h4;
      default: rank = 3'h0;
    endcase
  endfunction : rank
  // Worst rank reported by any source for one condition
  function automatic logic [2:0] worst(input slot_t [NUM_SRC-1:0] t, input int c);
    logic [2:0] w;
    w = 3'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (t[i].valid && rank(t[i].lvl[c]) > w) begin
        w = rank(t[i].lvl[c]);
      end
    end
    worst = w;
  endfunction : worst

  // ==========================================================
  // Events taken from the synchronised pins
  logic ev_pup, ev_pdn, ev_rst, btn_rise, post_ok;
  assign ev_pup = q.sync2.sys_pwr && !q.prev.sys_pwr;
  assign ev_pdn = !q.sync2.sys_pwr && q.prev.sys_pwr;
  assign ev_rst = (q.sync2.soft_rst && !q.prev.soft_rst) ||
                  (q.sync2.hard_rst && !q.prev.hard_rst);
  assign btn_rise = q.sync2.id_btn && !q.prev.id_btn;
  assign post_ok = q.sync2.sys_pwr && q.sync2.post_done;

  // ==========================================================
  // Command decode and slot lookup
  logic wr_go, cmd_go, cmd_acc;
  logic [7:0] cmd_src;
  logic [1:0] cmd_cond;
  logic [2:0] cmd_lvl;
  logic [NUM_SRC-1:0] hit, free;
  assign wr_go = !q.awready && !q.wready && !q.bvalid;
  assign cmd_go = wr_go && q.aw_addr == `OFS_CMD && (&q.wstrb[1:0]);
  assign cmd_src = q.wdata[`CMD_SRC_LSB +: 8];
  assign cmd_cond = q.wdata[`CMD_COND_LSB +: 2];
  assign cmd_lvl = q.wdata[`CMD_LVL_LSB +: 3];
  // Per-slot match and vacancy
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_slot
    assign hit[g] = q.tab[g].valid && q.tab[g].src == cmd_src;
    assign free[g] = !q.tab[g].valid;
  end
  // A bad level code is refused like a full table, so the sender retries
  assign cmd_acc = cmd_go && cmd_lvl <= LVL_DEGR && ((|hit) || (|free));

  // ==========================================================
  // Next state
  always_comb begin : next_state
    logic [SW-1:0] sel;
    logic [2:0] w_psu;
    logic [`COND_N-1:0][2:0] w;
    logic crit, nc, degr, rd_hit;
    logic [31:0] rd, clr, be;
    sel = '0;
    w_psu = 3'h0;
    w = '0;
    crit = 1'b0;
    nc = 1'b0;
    degr = 1'b0;
    rd = 32'h0000_0000;
    rd_hit = 1'b1;
    clr = 32'h0000_0000;
    be = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
    d = q;
    // Two-flop synchronisers, then an edge reference
    d.sync1 = pins;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    // Free-running blink divider shared by both colours
    if (q.blink_cnt == `BLINK_W'(BLINK_HALF_CYC - 1)) begin
      d.blink_cnt = '0;
      d.blink = !q.blink;
    end else begin
      d.blink_cnt = q.blink_cnt + `BLINK_W'(1);
    end
    // Write address and data are taken in either order
    if (q.awready && awvalid) begin
      d.awready = 1'b0;
      d.aw_addr = awaddr;
    end
    if (q.wready && wvalid) begin
      d.wready = 1'b0;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    // Register writes; the command acts at any system power state
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp = `RESP_OKAY;
      case (q.aw_addr)
        `OFS_CTRL: begin
          if (q.wstrb[0]) begin
            d.redun = q.wdata[`CTRL_REDUN];
          end
        end
        `OFS_CMD: begin
          d.cmd_ok = cmd_acc;
          d.cmd_rej = cmd_go && !cmd_acc;
        end
        `OFS_KEEP: clr = q.wdata & be;
        `OFS_RES, `OFS_STAT: ;
        default: d.bresp = `RESP_SLVERR;
      endcase
    end
    // A known source reuses its slot, a new one takes the lowest free slot
    if (cmd_acc) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (free[i]) begin
          sel = SW'(i);
        end
      end
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (hit[i]) begin
          sel = SW'(i);
        end
      end
      d.tab[sel].valid = 1'b1;
      d.tab[sel].src = cmd_src;
      d.tab[sel].lvl[cmd_cond] = cmd_lvl;
      // A source that reports all OK gives its slot back
      if (d.tab[sel].lvl == '0) begin
        d.tab[sel].valid = 1'b0;
      end
      if (cmd_cond == COND_PSU) begin
        d.psu_keep = 3'h0;
      end
    end
    // Power-down keeps the supply fault, the rest returns to default
    w_psu = worst(d.tab, COND_PSU);
    if (ev_pdn) begin
      d.psu_keep = (w_psu > q.psu_keep) ? w_psu : q.psu_keep;
    end
    if (ev_rst || ev_pup || ev_pdn) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        d.tab[i] = '0;
      end
    end
    if (ev_rst) begin
      d.psu_keep = 3'h0;
    end
    // Condition lamps from the worst report in effect
    for (int c = 0; c < `COND_N; c++) begin
      w[c] = worst(d.tab, c);
    end
    if (d.psu_keep > w[COND_PSU]) begin
      w[COND_PSU] = d.psu_keep;
    end
    for (int c = 0; c < `COND_N; c++) begin
      d.leds.cond[c] = w[c] != 3'h0;
      crit = crit || w[c] >= 3'h3;
      nc = nc || w[c] == 3'h2;
      degr = degr || w[c] == 3'h1;
    end
    // Retained lamps; a new fault wins over a software clear
    d.leds.dimm = (q.leds.dimm & ~clr[`KEEP_DIMM_LSB +: `DIMM_N]) |
                  q.sync2.dimm_err;
    d.leds.cpu = (q.leds.cpu & ~clr[`KEEP_CPU_LSB +: `CPU_N]) |
                 q.sync2.cpu_off;
    d.leds.fan = (q.leds.fan & ~clr[`KEEP_FAN_LSB +: `FAN_N]) |
                 q.sync2.fan_fail;
    // Overall system severity, most severe first
    crit = crit || q.sync2.thr_crit || q.sync2.pwr_ctrl_fault ||
           q.sync2.cpu_cfg_fail;
    nc = nc || q.sync2.thr_nc || q.sync2.intrusion;
    degr = degr || (q.redun && q.sync2.nonredun_pwr) || (|d.leds.cpu) ||
           q.sync2.mem_mapout;
    if (crit) begin
      d.sev = SEV_CRIT;
    end else if (nc) begin
      d.sev = SEV_NC;
    end else if (degr) begin
      d.sev = SEV_DEGR;
    end else begin
      d.sev = SEV_NORMAL;
    end
    // Status lamp is dark until power is on and self-test is done
    d.leds.stat_grn = 1'b0;
    d.leds.stat_amb = 1'b0;
    if (post_ok) begin
      case (d.sev)
        SEV_NORMAL: d.leds.stat_grn = 1'b1;
        SEV_DEGR: d.leds.stat_grn = q.blink;
        SEV_NC: d.leds.stat_amb = q.blink;
        default: d.leds.stat_amb = 1'b1;
      endcase
    end
    d.leds.brd_grn = d.leds.stat_grn;
    d.leds.brd_amb = d.leds.stat_amb;
    // Locator, standby presence and receiver assignment strobe
    if (btn_rise) begin
      d.leds.locator_lamp = !q.leds.locator_lamp;
    end
    d.leds.standby_presence_indicator = 1'b1;
    d.leds.event_rcv_assign = ev_pup || ev_rst;
    // Register reads answer one cycle after the address is taken
    case (araddr)
      `OFS_CTRL: rd[`CTRL_REDUN] = q.redun;
      `OFS_CMD: ;
      `OFS_RES: begin
        rd[`RES_OK] = q.cmd_ok;
        rd[`RES_REJ] = q.cmd_rej;
        rd[`RES_COND_LSB +: `COND_N] = q.leds.cond;
      end
      `OFS_KEEP: begin
        rd[`KEEP_DIMM_LSB +: `DIMM_N] = q.leds.dimm;
        rd[`KEEP_CPU_LSB +: `CPU_N] = q.leds.cpu;
        rd[`KEEP_FAN_LSB +: `FAN_N] = q.leds.fan;
      end
      `OFS_STAT: begin
        rd[`STAT_SEV_LSB +: 2] = q.sev;
        rd[`STAT_GRN] = q.leds.stat_grn;
        rd[`STAT_AMB] = q.leds.stat_amb;
        rd[`STAT_LOC] = q.leds.locator_lamp;
        rd[`STAT_PWR] = q.sync2.sys_pwr;
        rd[`STAT_POST] = q.sync2.post_done;
      end
      default: rd_hit = 1'b0;
    endcase
    if (q.arready && arvalid) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
  end

  // Register stage; lamps all start dark except the standby lamp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.leds.standby_presence_indicator <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign leds = q.leds;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rst_leds_off: assert property (ce && ev_rst |=> leds.cond == '0)
    else $error("condition lamps not cleared by reset");
  a_pdn_keep_psu: assert property (ce && ev_pdn && !ev_rst && !cmd_acc |=>
    !leds.cond[COND_FAN] && !leds.cond[COND_TEMP] && !leds.cond[COND_DRIVE] &&
    leds.cond[COND_PSU] == $past(leds.cond[COND_PSU]))
    else $error("power-down default restore wrong");
  a_crit_amber: assert property (ce && d.sev == SEV_CRIT && post_ok |=>
    leds.stat_amb && !leds.stat_grn)
    else $error("critical not steady amber");
  a_cond_lit: assert property (ce && cmd_acc && cmd_lvl != LVL_OK && !ev_rst &&
    !ev_pup && !ev_pdn |=> leds.cond[$past(cmd_cond)])
    else $error("non-OK report did not light lamp");
  a_track_wipe: assert property (ce && (ev_rst || ev_pup || ev_pdn) |=> &free)
    else $error("source table not wiped");
  a_assign_pulse: assert property (ce && (ev_pup || ev_rst) |=>
    leds.event_rcv_assign)
    else $error("receiver assignment not signalled");
  a_dimm_sticky: assert property (ce && (|q.sync2.dimm_err) |=> |leds.dimm)
    else $error("memory fault lamp missed");
  a_green_normal: assert property (ce && d.sev == SEV_NORMAL && post_ok |=>
    leds.stat_grn && !leds.stat_amb)
    else $error("normal state not steady green");
  a_dark_post: assert property (ce && !post_ok |=>
    !leds.stat_grn && !leds.stat_amb)
    else $error("status lamp lit during self-test");
  a_locator_toggle: assert property (ce && btn_rise |=>
    leds.locator_lamp != $past(leds.locator_lamp))
    else $error("locator did not toggle");
  a_board_mirror: assert property (leds.brd_grn == leds.stat_grn &&
    leds.brd_amb == leds.stat_amb)
    else $error("board status lamp differs");
  a_standby_lit: assert property (1'b1 |-> leds.standby_presence_indicator)
    else $error("standby lamp dark");
  a_full_reject: assert property (ce && cmd_go && !(|hit) && !(|free) |=>
    q.cmd_rej && !q.cmd_ok)
    else $error("full table did not reject");

endmodule : fault_led_aggregator

/* rtl/fault_led_cfg.svh */
// Offsets, field positions, sizes and timing of the fault LED block
`ifndef FAULT_LED_CFG_SVH
`define FAULT_LED_CFG_SVH
// ==========================================================
// Bus geometry and register offsets
`define AXI_AW 8
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_RES 8'h08
`define OFS_KEEP 8'h0C
`define OFS_STAT 8'h10
// ==========================================================
// Field positions
`define CTRL_REDUN 0
`define CMD_SRC_LSB 0
`define CMD_COND_LSB 8
`define CMD_LVL_LSB 10
`define RES_OK 0
`define RES_REJ 1
`define RES_COND_LSB 2
`define KEEP_DIMM_LSB 0
`define KEEP_CPU_LSB 8
`define KEEP_FAN_LSB 16
`define STAT_SEV_LSB 0
`define STAT_GRN 2
`define STAT_AMB 3
`define STAT_LOC 4
`define STAT_PWR 5
`define STAT_POST 6
// ==========================================================
// Sizes and timing
`define DIMM_N 6
`define CPU_N 2
`define FAN_N 6
`define COND_N 4
`define CLK_PERIOD_NS 32'h0000_000A
`define BLINK_HALF_NS 32'h1DCD_6500
`define BLINK_W 26
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* rtl/fault_led_pkg.sv */
// Shared types of the fault LED block
package fault_led_pkg;
  `include "fault_led_cfg.svh"
  typedef enum logic [2:0] {LVL_OK = 3'h0, LVL_NC = 3'h1, LVL_CRIT = 3'h2,
                            LVL_NR = 3'h3, LVL_DEGR = 3'h4} lvl_t;
  typedef enum logic [1:0] {COND_FAN = 2'h0, COND_TEMP = 2'h1,
                            COND_DRIVE = 2'h2, COND_PSU = 2'h3} cond_t;
  typedef enum logic [1:0] {SEV_NORMAL = 2'h0, SEV_DEGR = 2'h1,
                            SEV_NC = 2'h2, SEV_CRIT = 2'h3} sev_t;
  // Board level inputs, all asynchronous to aclk
  typedef struct packed {
    logic sys_pwr;
    logic soft_rst;
    logic hard_rst;
    logic id_btn;
    logic post_done;
    logic thr_crit;
    logic thr_nc;
    logic pwr_ctrl_fault;
    logic cpu_cfg_fail;
    logic intrusion;
    logic nonredun_pwr;
    logic mem_mapout;
    logic [`DIMM_N-1:0] dimm_err;
    logic [`CPU_N-1:0] cpu_off;
    logic [`FAN_N-1:0] fan_fail;
  } pin_t;
  // One tracked command source
  typedef struct packed {
    logic valid;
    logic [7:0] src;
    logic [`COND_N-1:0][2:0] lvl;
  } slot_t;
  // Lamp outputs
  typedef struct packed {
    logic [`COND_N-1:0] cond;
    logic [`DIMM_N-1:0] dimm;
    logic [`CPU_N-1:0] cpu;
    logic [`FAN_N-1:0] fan;
    logic stat_grn;
    logic stat_amb;
    logic brd_grn;
    logic brd_amb;
    logic locator_lamp;
    logic standby_presence_indicator;
    logic event_rcv_assign;
  } led_t;
endpackage : fault_led_pkg

/* testbench/satellite_model.sv */
// Satellite controller model that sends fault commands over AXI4-Lite
`timescale 1ns/100ps
`include "fault_led_cfg.svh"
module satellite_model (
  input wire logic aclk, // Clock
  output logic awvalid, // Address valid
  input wire logic awready, // Address ready
  output logic [`AXI_AW-1:0] awaddr, // Write address
  output logic wvalid, // Data valid
  input wire logic wready, // Data ready
  output logic [31:0] wdata, // Write data
  output logic [3:0] wstrb, // Strobes
  input wire logic bvalid, // Response valid
  output logic bready, // Response ready
  input wire logic [1:0] bresp, // Response code
  output logic arvalid, // Read valid
  input wire logic arready, // Read ready
  output logic [`AXI_AW-1:0] araddr, // Read address
  input wire logic rvalid, // Data valid
  output logic rready, // Data ready
  input wire logic [31:0] rdata, // Read data
  input wire logic [1:0] rresp, // Read code
  input wire logic resend_req, // Receiver assigned
  output logic polling // Own polls in flight
);
  int n_assign;
  logic [31:0] last_cmd;
  // ==========================================================
  // Idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, polling} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    n_assign = 0;
    last_cmd = 32'h0000_0000;
  end
  // Each assignment obliges us to resend our present state
  always @(posedge aclk) if (resend_req) n_assign <= n_assign + 1;
  // Released lines carry the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awvalid && awready) {awvalid, awaddr} <= {1'h0, ~a};
      if (wvalid && wready) {wvalid, wdata} <= {1'h0, ~d};
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arvalid && arready) {arvalid, araddr} <= {1'h0, ~a};
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd
  // Send one command, poll the result and retry while refused
  task automatic cmd(input logic [31:0] c, input int tries, output logic ok);
    logic [1:0] r;
    logic [31:0] d;
    ok = 1'h0;
    last_cmd = c;
    polling <= 1'h1;
    for (int i = 0; i < tries && !ok; i++) begin
      wr(`OFS_CMD, c, r);
      rd(`OFS_RES, d, r);
      ok = d[`RES_OK];
    end
    polling <= 1'h0;
  endtask : cmd
  task automatic resend(output logic ok);
    cmd(last_cmd, 4, ok);
  endtask : resend
endmodule : satellite_model

/* testbench/tb.sv */
// Self-checking bench of the fault LED aggregator with a satellite partner
`timescale 1ns/100ps
`include "fault_led_cfg.svh"
module tb import fault_led_pkg::*; ;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, polling, ok;
  logic [`AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  logic [5:0] dm, fm;
  logic [65:0] nr;
  logic [65:0] q_r[$];
  logic [1:0] q_b[$];
  pin_t pins;
  led_t leds;
  int n_errors, comparisons, cyc, b, na;
  int pb[7] = '{20, 19, 18, 17, 16, 14, 15};
  int ps[7] = '{3, 2, 3, 3, 2, 1, 1};
  // ==========================================================
  // Design and partner
  fault_led_aggregator #(.NUM_SRC(4), .BLINK_HALF_CYC(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pins(pins), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .leds(leds));
  satellite_model sat (
    .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .resend_req(leds.event_rcv_assign),
    .polling(polling));
  // ==========================================================
  // Clock and hang guard
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // Answers are compared with the oldest note; the partner's own polls are skipped
  always @(posedge aclk) begin
    if (rvalid && rready && !polling) begin
      nr = q_r.pop_front();
      chk("rresp", 32'(nr[65:64]), 32'(rresp));
      chk("rdata", nr[31:0], rdata & nr[63:32]);
    end
    if (bvalid && bready && !polling) chk("bresp", 32'(q_b.pop_front()), 32'(bresp));
    chk("board lamp", 32'({leds.stat_grn, leds.stat_amb}), 32'({leds.brd_grn, leds.brd_amb}));
  end
  // ==========================================================
  // Drivers
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    q_b.push_back(e);
    sat.wr(a, d, rr);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                   input logic [1:0] er);
    q_r.push_back({er, m, e & m});
    sat.rd(a, rd_d, rr);
  endtask : r
  task automatic cm(input int s, input int c, input int l, input int t);
    sat.cmd({19'h0, 3'(l), 2'(c), 8'(s)}, t, ok);
    repeat (2) @(posedge aclk);
  endtask : cm
  // Five cycles cover the two sync flops and the edge reference
  task automatic pin(input int i, input logic v);
    pins[i] <= v;
    repeat (5) @(posedge aclk);
  endtask : pin
  // Half duty blink puts exactly half of 16 cycles on
  task automatic lamp_mix(input int sev);
    int g, a;
    g = 0;
    a = 0;
    repeat (16) begin
      @(posedge aclk);
      g += leds.stat_grn;
      a += leds.stat_amb;
    end
    chk("green", 32'(sev == 0 ? 16 : sev == 1 ? 8 : 0), 32'(g));
    chk("amber", 32'(sev == 3 ? 16 : sev == 2 ? 8 : 0), 32'(a));
  endtask : lamp_mix
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hc6ca_8df7));
    {aresetn, ce, pins, cyc} = {1'h0, 1'h1, 26'h0, 32'h0};
    b = $urandom_range(200, 16);
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("leds", 32'h0000_0002, 32'(leds));
    chk("standby", 32'h0000_0001, 32'(leds.standby_presence_indicator));
    r(`OFS_STAT, 32'h0000_0000, 32'h0000_007F, `RESP_OKAY);
    r(8'h14, 32'h0000_0000, 32'hFFFF_FFFF, `RESP_SLVERR);
    w(8'h14, 32'hFFFF_FFFF, `RESP_SLVERR);
    w(`OFS_CTRL, 32'h0000_0001, `RESP_OKAY);
    r(`OFS_CTRL, 32'h0000_0001, 32'h0000_0001, `RESP_OKAY);
    $display("test reset done");
    // Source tracking with the system off
    cm(b, 0, 1, 1);
    cm(b + 1, 0, 2, 1);
    chk("cond", 32'h0000_0001, 32'(leds.cond));
    r(`OFS_RES, 32'h0000_0005, 32'h0000_003F, `RESP_OKAY);
    cm(b, 0, 0, 1);
    chk("cond", 32'h0000_0001, 32'(leds.cond));
    cm(b + 1, 0, 0, 1);
    chk("cond", 32'h0000_0000, 32'(leds.cond));
    for (int i = 0; i < 4; i++) cm(b + i, i, 1, 1);
    chk("cond", 32'h0000_000F, 32'(leds.cond));
    cm(b + 4, 1, 2, 3);
    chk("refused", 32'h0000_0000, 32'(ok));
    r(`OFS_RES, 32'h0000_003E, 32'h0000_003F, `RESP_OKAY);
    na = sat.n_assign;
    pin(24, 1'h1);
    pin(24, 1'h0);
    chk("cond", 32'h0000_0000, 32'(leds.cond));
    chk("assign", 32'(na + 1), 32'(sat.n_assign));
    cm(b, 0, 5, 1);
    chk("bad level", 32'h0000_0000, 32'(ok));
    cm(b + 4, 1, 2, 1);
    chk("accepted", 32'h0000_0001, 32'(ok));
    pin(23, 1'h1);
    pin(23, 1'h0);
    chk("cond", 32'h0000_0000, 32'(leds.cond));
    sat.resend(ok);
    repeat (2) @(posedge aclk);
    chk("cond", 32'h0000_0002, 32'(leds.cond));
    $display("test tracking done");
    // Levels and conditions with the system running
    na = sat.n_assign;
    pin(25, 1'h1);
    chk("assign", 32'(na + 1), 32'(sat.n_assign));
    pin(21, 1'h1);
    lamp_mix(0);
    for (int c = 0; c < 4; c++) begin
      for (int l = 1; l < 5; l++) begin
        cm(b + 5, c, l, 1);
        chk("cond", 32'(1 << c), 32'(leds.cond));
        r(`OFS_STAT, 32'(l == 1 ? 2 : l == 4 ? 1 : 3), 32'h0000_0003, `RESP_OKAY);
        cm(b + 5, c, 0, 1);
      end
    end
    cm(b, 0, 1, 1);
    cm(b + 1, 1, 3, 1);
    r(`OFS_STAT, 32'h0000_0003, 32'h0000_0003, `RESP_OKAY);
    cm(b + 1, 1, 0, 1);
    lamp_mix(2);
    cm(b, 0, 2, 1);
    cm(b, 3, 2, 1);
    pin(25, 1'h0);
    chk("cond", 32'h0000_0008, 32'(leds.cond));
    pin(25, 1'h1);
    pin(24, 1'h1);
    pin(24, 1'h0);
    chk("cond", 32'h0000_0000, 32'(leds.cond));
    $display("test levels done");
    // Status sources on board pins
    for (int i = 0; i < 7; i++) begin
      pin(pb[i], 1'h1);
      r(`OFS_STAT, 32'(ps[i]), 32'h0000_0003, `RESP_OKAY);
      lamp_mix(ps[i]);
      pin(pb[i], 1'h0);
    end
    w(`OFS_CTRL, 32'h0000_0000, `RESP_OKAY);
    pin(15, 1'h1);
    r(`OFS_STAT, 32'h0000_0000, 32'h0000_0003, `RESP_OKAY);
    pin(15, 1'h0);
    $display("test status done");
    // Retained lamps survive resets and power cycles
    dm = 6'($urandom_range(63, 1));
    fm = 6'($urandom_range(63, 1));
    {pins.dimm_err, pins.cpu_off, pins.fan_fail} <= {dm, 2'h2, fm};
    repeat (5) @(posedge aclk);
    {pins.dimm_err, pins.cpu_off, pins.fan_fail} <= 14'h0000;
    repeat (5) @(posedge aclk);
    pin(24, 1'h1);
    pin(24, 1'h0);
    pin(25, 1'h0);
    pin(25, 1'h1);
    chk("dimm", 32'(dm), 32'(leds.dimm));
    chk("cpu", 32'h0000_0002, 32'(leds.cpu));
    chk("fan", 32'(fm), 32'(leds.fan));
    r(`OFS_STAT, 32'h0000_0001, 32'h0000_0003, `RESP_OKAY);
    r(`OFS_KEEP, {10'h0, fm, 6'h0, 2'h2, 2'h0, dm}, 32'h003F_033F, `RESP_OKAY);
    w(`OFS_KEEP, 32'hFFFF_FFFF, `RESP_OKAY);
    r(`OFS_KEEP, 32'h0000_0000, 32'h003F_033F, `RESP_OKAY);
    $display("test retained done");
    // Locator toggles on each press
    pin(22, 1'h1);
    pin(22, 1'h0);
    chk("locator", 32'h0000_0001, 32'(leds.locator_lamp));
    pin(22, 1'h1);
    pin(22, 1'h0);
    chk("locator", 32'h0000_0000, 32'(leds.locator_lamp));
    // A press made while the clock enable is low must go unseen
    ce <= 1'h0;
    pin(22, 1'h1);
    pin(22, 1'h0);
    ce <= 1'h1;
    repeat (5) @(posedge aclk);
    chk("frozen", 32'h0000_0000, 32'(leds.locator_lamp));
    $display("test locator done");
    summarize();
  end
endmodule : tb
